/* inc/fpm_pkg.sv */
// fpm_pkg: constants and carrier types of the flash program mode control
// assumes an 8-bit sfr bus and a 64 KB flash array behind the block
package fpm_pkg;
  // sfr offsets
  localparam logic [7:0] FPM_MODE_ADDR = 8'hea;
  localparam logic [7:0] FPM_STATUS_ADDR = 8'heb;
  localparam logic [7:0] FPM_TIME_ADDR = 8'hec;
  localparam logic [7:0] FPM_ADDRH_ADDR = 8'hf2;
  localparam logic [7:0] FPM_ADDRM_ADDR = 8'hf3;
  localparam logic [7:0] FPM_ADDRL_ADDR = 8'hf4;
  localparam logic [7:0] FPM_DATA_ADDR = 8'hf5;
  localparam logic [7:0] FPM_CTRL_ADDR = 8'hf6;
  // values after reset
  localparam logic [7:0] FPM_MODE_RST = 8'h00;
  localparam logic [7:0] FPM_STATUS_RST = 8'h80;
  localparam logic [7:0] FPM_TIME_RST = 8'h00;
  localparam logic [7:0] FPM_ADDR_RST = 8'h00;
  localparam logic [7:0] FPM_DATA_RST = 8'h00;
  localparam logic [7:0] FPM_CTRL_RST = 8'h03;
  // mode register fields
  localparam int FPM_M_ARRAY = 7;
  localparam int FPM_M_PGM = 5;
  localparam int FPM_M_ERASE = 4;
  localparam int FPM_M_PBUF = 3;
  localparam int FPM_M_OTP = 2;
  localparam int FPM_M_VFY = 1;
  localparam int FPM_M_GATE = 0;
  // status register fields
  localparam int FPM_S_DONE = 7;
  localparam int FPM_S_VGOOD = 6;
  localparam int FPM_S_CRC = 5;
  localparam int FPM_S_INT = 3;
  localparam int FPM_S_WMODE = 2;
  localparam int FPM_S_EMODE = 1;
  localparam int FPM_S_VMODE = 0;
  // control register fields
  localparam int FPM_C_WRITE = 3;
  localparam int FPM_C_READ = 2;
  // eeprom entry sequence
  localparam logic [7:0] FPM_EEP_KEY1 = 8'ha5;
  localparam logic [7:0] FPM_EEP_KEY2 = 8'h5a;
  // timing: system clock divided by 128 drives the 10-bit timer
  localparam int FPM_PRESCALE = 128;
  localparam int FPM_PRE_W = 7;
  localparam logic [6:0] FPM_PRE_LAST = 7'(FPM_PRESCALE - 1);
  localparam int FPM_TMR_W = 10;
  localparam int FPM_ARRAY_AW = 16;

  typedef enum logic [1:0]
  {
    FPM_IDLE = 2'b00,
    FPM_RUN = 2'b01,
    FPM_READ = 2'b11
  } fpm_state_e;

  typedef struct packed
  {
    logic [FPM_ARRAY_AW-1:0] addr;
    logic [7:0] wdata;
    logic program_op;
    logic erase_op;
    logic verify_op;
    logic read_strobe;
    logic array_select;
    logic page_buffer_select;
    logic one_time_area_select;
    logic eeprom_select;
    logic normal_read_ok;
  } fpm_flash_s;
endpackage : fpm_pkg

/* sim/fpm_ctrl_bench.sv */
// fpm_ctrl_bench: self-checking bench of the flash program mode control
// assumes the flash model answers reads in the strobe cycle
`define CHK(what, exp, got) \
  begin \
    n_compared++; \
    if ((got) !== (exp)) \
    begin \
      err_total++; \
      $display("wrong value %s expected %h seen %h", what, exp, got); \
    end \
  end
module fpm_ctrl_bench;
  timeunit 1ns;
  timeprecision 1ns;
  import fpm_pkg::*;
  logic core_clk_in = 1'b0;
  logic srst_in = 1'b1;
  logic prog_mode_in = 1'b1;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic pass = 1'b0;
  logic vok;
  logic [7:0] addr = 8'h00;
  logic [7:0] wdata = 8'h00;
  logic [7:0] rdata;
  logic [7:0] frd;
  logic [7:0] got;
  logic [7:0] v;
  logic [15:0] a;
  fpm_flash_s fo;
  int err_total = 0;
  int n_compared = 0;
  logic [7:0] ra [9] = '{8'hea, 8'heb, 8'hec, 8'hf2, 8'hf3, 8'hf4, 8'hf5,
    8'hf6, 8'hed};
  logic [7:0] re [9] = '{8'h00, 8'h80, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
    8'h03, 8'h00};
  logic [7:0] om [6] = '{8'h21, 8'h11, 8'h31, 8'h23, 8'h12, 8'h21};
  logic [7:0] ot [6] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h01};

  always #5 core_clk_in = ~core_clk_in;

  fpm_ctrl u_fpm_ctrl (.core_clk_in(core_clk_in), .srst_in(srst_in),
    .prog_mode_in(prog_mode_in), .sfr_addr_in(addr), .sfr_wr_in(wr),
    .sfr_rd_in(rd), .sfr_wdata_in(wdata), .sfr_rdata_out(rdata),
    .flash_rdata_in(frd), .verify_ok_in(vok), .flash_out(fo));
  fpm_flash_model u_fpm_flash_model (.core_clk_in(core_clk_in),
    .srst_in(srst_in), .flash_in(fo), .verify_pass_in(pass),
    .rdata_out(frd), .verify_ok_out(vok));

  task automatic results();
    $display("compared %0d mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : results

  task automatic wr_reg(input logic [7:0] ad, input logic [7:0] d);
    @(posedge core_clk_in);
    addr <= ad;
    wdata <= d;
    wr <= 1'b1;
    @(posedge core_clk_in);
    wr <= 1'b0;
  endtask : wr_reg

  task automatic rd_reg(input logic [7:0] ad, output logic [7:0] d);
    @(posedge core_clk_in);
    addr <= ad;
    rd <= 1'b1;
    @(posedge core_clk_in);
    rd <= 1'b0;
    #1 d = rdata;
  endtask : rd_reg

  // time counts from the start write, status poll included
  task automatic run_op(input logic [7:0] m, input logic [7:0] t);
    int n;
    int lim;
    logic seen;
    logic verify_select;
    logic [2:0] fl;
    n = 0;
    seen = 1'b0;
    verify_select = m[FPM_M_VFY];
    fl = {m[5] & ~verify_select, m[4] & ~verify_select, verify_select & (m[5] | m[4])};
    lim = FPM_PRESCALE * t + 300;
    wr_reg(FPM_TIME_ADDR, t);
    wr_reg(FPM_MODE_ADDR, m);
    wr_reg(FPM_CTRL_ADDR, 8'h08);
    if (t != 8'h00)
    begin
      rd_reg(FPM_STATUS_ADDR, got);
      `CHK("busy flag", 1'b0, got[FPM_S_DONE])
      n = 2;
    end
    while (n < lim)
    begin
      #1;
      if (fo.program_op || fo.erase_op || fo.verify_op)
      begin
        if (!seen)
        begin
          `CHK("verify_op", verify_select, fo.verify_op)
          if (!verify_select)
          begin
            `CHK("program_op", m[5], fo.program_op)
            `CHK("erase_op", m[4] & ~m[5], fo.erase_op)
          end
        end
        seen = 1'b1;
      end
      else if (seen)
        break;
      @(posedge core_clk_in);
      n++;
    end
    if (n >= lim)
    begin
      err_total++;
      results();
    end
    `CHK("op time", 1'b1, n >= FPM_PRESCALE * t
      && n <= FPM_PRESCALE * t + 8)
    rd_reg(FPM_STATUS_ADDR, got);
    `CHK("status", 8'h88, got & 8'h88)
    `CHK("mode flags", fl, got[2:0])
    if (verify_select)
      `CHK("verify good", pass, got[FPM_S_VGOOD])
  endtask : run_op

  initial
  begin
    void'($urandom(56661));
    repeat (16) @(posedge core_clk_in);
    srst_in <= 1'b0;
    for (int i = 0; i < 9; i++)
    begin
      rd_reg(ra[i], got);
      `CHK("reset read", re[i], got)
    end
    @(posedge core_clk_in);
    prog_mode_in <= 1'b0;
    wr_reg(FPM_MODE_ADDR, 8'hff);
    wr_reg(FPM_TIME_ADDR, 8'hff);
    rd_reg(FPM_MODE_ADDR, got);
    `CHK("blocked read", 8'h00, got)
    @(posedge core_clk_in);
    prog_mode_in <= 1'b1;
    rd_reg(FPM_MODE_ADDR, got);
    `CHK("blocked write", 8'h00, got)
    rd_reg(FPM_TIME_ADDR, got);
    `CHK("blocked time", 8'h00, got)
    repeat (8)
    begin
      v = 8'($urandom);
      wr_reg(FPM_MODE_ADDR, v);
      rd_reg(FPM_MODE_ADDR, got);
      `CHK("mode", v & 8'hbf, got)
      `CHK("array sel", v[7], fo.array_select)
      `CHK("page sel", v[3], fo.page_buffer_select)
      `CHK("otp sel", v[2], fo.one_time_area_select)
      `CHK("normal read", ~v[0], fo.normal_read_ok)
    end
    repeat (4)
    begin
      a = 16'($urandom);
      wr_reg(FPM_MODE_ADDR, 8'h80);
      wr_reg(FPM_ADDRM_ADDR, a[15:8]);
      wr_reg(FPM_ADDRL_ADDR, a[7:0]);
      wr_reg(FPM_CTRL_ADDR, 8'h04);
      repeat (2) @(posedge core_clk_in);
      rd_reg(FPM_DATA_ADDR, got);
      `CHK("array addr", a, fo.addr)
      `CHK("read data", a[7:0] ^ a[15:8] ^ 8'h3c, got)
    end
    for (int i = 0; i < 6; i++)
    begin
      pass <= i[0];
      run_op(om[i], ot[i]);
    end
    // software clear reaches flags 6 and 3 only, done stays set
    wr_reg(FPM_STATUS_ADDR, 8'h00);
    rd_reg(FPM_STATUS_ADDR, got);
    `CHK("status clear", 8'h80, got & 8'hc8)
    // no gate: a program or erase start request must not launch anything
    foreach (om[i])
    begin
      if (i < 2)
      begin
        wr_reg(FPM_MODE_ADDR, om[i] & 8'hfe);
        wr_reg(FPM_CTRL_ADDR, 8'h08);
        repeat (20)
        begin
          @(posedge core_clk_in);
          #1 `CHK("gated", 1'b0, fo.program_op | fo.erase_op)
        end
      end
    end
    `CHK("eeprom before", 1'b0, fo.eeprom_select)
    wr_reg(FPM_DATA_ADDR, FPM_EEP_KEY1);
    wr_reg(FPM_DATA_ADDR, FPM_EEP_KEY2);
    repeat (2) @(posedge core_clk_in);
    #1 `CHK("eeprom after", 1'b1, fo.eeprom_select)
    `CHK("data out", FPM_EEP_KEY2, fo.wdata)
    results();
  end
endmodule : fpm_ctrl_bench

/* sim/fpm_flash_model.sv */
// fpm_flash_model: behavioural flash macro facing the control block
// assumes read_strobe is a one-cycle pulse and data is taken that cycle
module fpm_flash_model
(
  // clock and reset
  input wire logic core_clk_in,
  input wire logic srst_in,
  // control side
  input wire fpm_pkg::fpm_flash_s flash_in,
  input wire logic verify_pass_in,
  // answers
  output logic [7:0] rdata_out,
  output logic verify_ok_out
);
  timeunit 1ns;
  timeprecision 1ns;
  import fpm_pkg::*;
  logic [7:0] noise;

  // outside a read the bus never holds a stale byte
  always_ff @(posedge core_clk_in)
  begin
    noise <= srst_in ? 8'h5c : noise + 8'h3b;
  end

  assign rdata_out = flash_in.read_strobe ?
    (flash_in.addr[7:0] ^ flash_in.addr[15:8] ^ 8'h3c) : noise;
  assign verify_ok_out = flash_in.verify_op ? verify_pass_in : noise[0];
endmodule : fpm_flash_model

/* src/fpm_ctrl.sv */
// fpm_ctrl: sfr register set and sequencer for flash and eeprom programming
// assumes a cpu sfr port with one-cycle read and write strobes, and a flash
// macro returning read data and verify result in the same cycle as the request

// Behaviour
// [RULE_01] register access only in programming mode
// [RULE_02] one register set serves flash and eeprom
// [RULE_03] flash array address spans 64 kilobytes
// [RULE_04] mode bit 5 enables program or verify
// [RULE_05] mode bit 4 enables erase or verify
// [RULE_06] program plus verify bit runs program verify
// [RULE_07] erase plus verify bit runs erase verify
// [RULE_08] mode bit 0 gates program and erase
// [RULE_09] gate cleared keeps array normally readable
// [RULE_10] mode bit 7 selects the flash array
// [RULE_11] bit 3 page buffer, bit 2 otp area
// [RULE_12] busy flag clears at start, sets at end
// [RULE_13] ten-bit timer clears, stops at time value
// [RULE_14] software writes a5 then 5a for eeprom
module fpm_ctrl
(
  // clock and reset
  input wire logic core_clk_in,
  input wire logic srst_in,
  // chip mode
  input wire logic prog_mode_in,
  // sfr bus
  input wire logic [7:0] sfr_addr_in,
  input wire logic sfr_wr_in,
  input wire logic sfr_rd_in,
  input wire logic [7:0] sfr_wdata_in,
  output logic [7:0] sfr_rdata_out,
  // flash macro
  input wire logic [7:0] flash_rdata_in,
  input wire logic verify_ok_in,
  output fpm_pkg::fpm_flash_s flash_out
);
  import fpm_pkg::*;

  logic [7:0] flash_mode_reg, flash_status_reg, flash_time_ctrl_reg;
  logic [7:0] flash_addr_high_reg, flash_addr_mid_reg, flash_addr_low_reg;
  logic [7:0] flash_data_reg, flash_control_reg;
  logic [7:0] next_mode, next_status, next_time, next_data;
  logic [7:0] next_addr_high, next_addr_mid, next_addr_low;
  logic [7:0] next_control, next_rdata;
  logic eep_key_seen, next_eep_key_seen;
  logic eeprom_mode, next_eeprom_mode;
  fpm_state_e state, next_state;
  fpm_flash_s next_flash;
  logic wr_ok, rd_ok, start_op, start_read;
  logic program_enable, ers, verify_select, gate, tmr_done;

  fpm_timer u_timer
  (
    .core_clk_in(core_clk_in),
    .srst_in(srst_in),
    .start_in(start_op),
    .limit_in(flash_time_ctrl_reg),
    .done_out(tmr_done),
    .count_out()
  );

  always_comb
  begin
    // blocked outside programming mode
    wr_ok = sfr_wr_in && prog_mode_in; // RULE_01
    rd_ok = sfr_rd_in && prog_mode_in; // RULE_01
    program_enable = flash_mode_reg[FPM_M_PGM]; // RULE_04
    ers = flash_mode_reg[FPM_M_ERASE]; // RULE_05
    verify_select = flash_mode_reg[FPM_M_VFY];
    gate = flash_mode_reg[FPM_M_GATE];
    // verify only reads cells, so it needs no gate
    start_op = wr_ok && sfr_addr_in == FPM_CTRL_ADDR
      && sfr_wdata_in[FPM_C_WRITE] && state == FPM_IDLE
      && (program_enable || ers) && (gate || verify_select); // RULE_08
    start_read = wr_ok && sfr_addr_in == FPM_CTRL_ADDR
      && sfr_wdata_in[FPM_C_READ] && state == FPM_IDLE
      && !program_enable && !ers;
    next_mode = flash_mode_reg;
    next_status = flash_status_reg;
    next_time = flash_time_ctrl_reg;
    next_addr_high = flash_addr_high_reg;
    next_addr_mid = flash_addr_mid_reg;
    next_addr_low = flash_addr_low_reg;
    next_data = flash_data_reg;
    next_control = flash_control_reg;
    next_eep_key_seen = eep_key_seen;
    next_eeprom_mode = eeprom_mode;
    next_state = state;
    if (wr_ok)
    begin
      case (sfr_addr_in)
        FPM_MODE_ADDR: next_mode = sfr_wdata_in & 8'hbf;
        FPM_STATUS_ADDR:
        begin
          next_status[FPM_S_VGOOD] = sfr_wdata_in[FPM_S_VGOOD];
          next_status[FPM_S_INT] = sfr_wdata_in[FPM_S_INT];
        end
        FPM_TIME_ADDR: next_time = sfr_wdata_in;
        FPM_ADDRH_ADDR: next_addr_high = sfr_wdata_in;
        FPM_ADDRM_ADDR: next_addr_mid = sfr_wdata_in;
        FPM_ADDRL_ADDR: next_addr_low = sfr_wdata_in;
        FPM_DATA_ADDR:
        begin
          next_data = sfr_wdata_in;
          // entry key pair must arrive back to back on this register
          next_eep_key_seen = (sfr_wdata_in == FPM_EEP_KEY1); // RULE_14
          if (eep_key_seen && sfr_wdata_in == FPM_EEP_KEY2)
          begin
            next_eeprom_mode = 1'b1; // RULE_14
          end
        end
        FPM_CTRL_ADDR: next_control = sfr_wdata_in & 8'hbf;
        default: next_control = flash_control_reg;
      endcase
    end
    case (state)
      FPM_IDLE:
      begin
        if (start_op)
        begin
          next_state = FPM_RUN;
          next_status[FPM_S_DONE] = 1'b0; // RULE_12
          next_status[FPM_S_INT] = 1'b0;
        end
        else if (start_read)
        begin
          next_state = FPM_READ;
        end
      end
      FPM_RUN:
      begin
        if (tmr_done)
        begin
          next_state = FPM_IDLE;
          // hardware set wins over a software clear in the same cycle
          next_status[FPM_S_DONE] = 1'b1; // RULE_12
          next_status[FPM_S_INT] = 1'b1;
          next_control[FPM_C_WRITE] = 1'b0;
          if (verify_select)
          begin
            next_status[FPM_S_VGOOD] = verify_ok_in;
          end
        end
      end
      FPM_READ:
      begin
        next_state = FPM_IDLE;
        next_data = flash_rdata_in;
        next_control[FPM_C_READ] = 1'b0;
      end
      default: next_state = FPM_IDLE;
    endcase
    next_status[FPM_S_WMODE] = program_enable && !verify_select;
    next_status[FPM_S_EMODE] = ers && !verify_select;
    next_status[FPM_S_VMODE] = verify_select && (program_enable || ers);
    next_status[4] = 1'b0;
    next_rdata = 8'h00;
    if (rd_ok)
    begin
      case (sfr_addr_in)
        FPM_MODE_ADDR: next_rdata = flash_mode_reg;
        FPM_STATUS_ADDR: next_rdata = flash_status_reg;
        FPM_TIME_ADDR: next_rdata = flash_time_ctrl_reg;
        FPM_DATA_ADDR: next_rdata = flash_data_reg;
        FPM_CTRL_ADDR: next_rdata = flash_control_reg;
        // address registers are write only; checksum readback not built
        default: next_rdata = 8'h00;
      endcase
    end
    // one register group drives flash or eeprom alike
    next_flash.addr = {flash_addr_mid_reg, flash_addr_low_reg}; // RULE_03
    next_flash.wdata = flash_data_reg; // RULE_02
    next_flash.program_op = next_state == FPM_RUN && program_enable && !verify_select
      && gate; // RULE_04
    next_flash.erase_op = next_state == FPM_RUN && ers && !verify_select && !program_enable
      && gate; // RULE_05
    next_flash.verify_op = next_state == FPM_RUN && verify_select
      && (program_enable || ers); // RULE_06 RULE_07
    next_flash.read_strobe = next_state == FPM_READ;
    next_flash.array_select = flash_mode_reg[FPM_M_ARRAY]; // RULE_10
    next_flash.page_buffer_select = flash_mode_reg[FPM_M_PBUF]; // RULE_11
    next_flash.one_time_area_select = flash_mode_reg[FPM_M_OTP]; // RULE_11
    next_flash.eeprom_select = next_eeprom_mode; // RULE_02
    next_flash.normal_read_ok = !next_mode[FPM_M_GATE]; // RULE_09
  end

  always_ff @(posedge core_clk_in)
  begin
    if (srst_in)
    begin
      flash_mode_reg <= FPM_MODE_RST;
      flash_status_reg <= FPM_STATUS_RST;
      flash_time_ctrl_reg <= FPM_TIME_RST;
      flash_addr_high_reg <= FPM_ADDR_RST;
      flash_addr_mid_reg <= FPM_ADDR_RST;
      flash_addr_low_reg <= FPM_ADDR_RST;
      flash_data_reg <= FPM_DATA_RST;
      flash_control_reg <= FPM_CTRL_RST;
      eep_key_seen <= 1'b0;
      eeprom_mode <= 1'b0;
      state <= FPM_IDLE;
      sfr_rdata_out <= 8'h00;
      flash_out <= '0;
    end
    else
    begin
      flash_mode_reg <= next_mode;
      flash_status_reg <= next_status;
      flash_time_ctrl_reg <= next_time;
      flash_addr_high_reg <= next_addr_high;
      flash_addr_mid_reg <= next_addr_mid;
      flash_addr_low_reg <= next_addr_low;
      flash_data_reg <= next_data;
      flash_control_reg <= next_control;
      eep_key_seen <= next_eep_key_seen;
      eeprom_mode <= next_eeprom_mode;
      state <= next_state;
      sfr_rdata_out <= next_rdata;
      flash_out <= next_flash;
    end
  end

  property p_no_access;
    @(posedge core_clk_in) disable iff (srst_in)
    (!prog_mode_in && sfr_wr_in)
      |=> $stable(flash_mode_reg) && $stable(flash_time_ctrl_reg);
  endproperty
  a_no_access: assert property (p_no_access) // RULE_01
    else $error("register written outside programming mode");
  property p_no_read;
    @(posedge core_clk_in) disable iff (srst_in)
    (!prog_mode_in && sfr_rd_in) |=> (sfr_rdata_out == 8'h00);
  endproperty
  a_no_read: assert property (p_no_read) // RULE_01
    else $error("register read outside programming mode");
  property p_gate;
    @(posedge core_clk_in) disable iff (srst_in)
    (flash_out.program_op || flash_out.erase_op)
      |-> $past(flash_mode_reg[FPM_M_GATE]);
  endproperty
  a_gate: assert property (p_gate) // RULE_08
    else $error("program or erase without gate");
  property p_busy_clear;
    @(posedge core_clk_in) disable iff (srst_in)
    start_op |=> !flash_status_reg[FPM_S_DONE] && state == FPM_RUN;
  endproperty
  a_busy_clear: assert property (p_busy_clear) // RULE_12
    else $error("busy flag not cleared at start");
  property p_busy_set;
    @(posedge core_clk_in) disable iff (srst_in)
    (state == FPM_RUN && tmr_done)
      |=> flash_status_reg[FPM_S_DONE] && state == FPM_IDLE;
  endproperty
  a_busy_set: assert property (p_busy_set) // RULE_12
    else $error("done flag not set at end");
  property p_pverify;
    @(posedge core_clk_in) disable iff (srst_in)
    (start_op && program_enable && verify_select) |=> flash_out.verify_op
      && !flash_out.program_op;
  endproperty
  a_pverify: assert property (p_pverify) // RULE_06
    else $error("program verify not entered");
  property p_everify;
    @(posedge core_clk_in) disable iff (srst_in)
    (start_op && ers && verify_select) |=> flash_out.verify_op
      && !flash_out.erase_op;
  endproperty
  a_everify: assert property (p_everify) // RULE_07
    else $error("erase verify not entered");
  property p_program;
    @(posedge core_clk_in) disable iff (srst_in)
    (start_op && program_enable && !verify_select) |=> flash_out.program_op;
  endproperty
  a_program: assert property (p_program) // RULE_04
    else $error("program not entered");
  property p_erase_off;
    @(posedge core_clk_in) disable iff (srst_in)
    flash_out.erase_op |-> $past(flash_mode_reg[FPM_M_ERASE]);
  endproperty
  a_erase_off: assert property (p_erase_off) // RULE_05
    else $error("erase active with erase bit clear");
  property p_select;
    @(posedge core_clk_in) disable iff (srst_in)
    ##1 flash_out.array_select == $past(flash_mode_reg[FPM_M_ARRAY])
      && flash_out.one_time_area_select == $past(flash_mode_reg[FPM_M_OTP]);
  endproperty
  a_select: assert property (p_select) // RULE_10 RULE_11
    else $error("select outputs disagree with mode");
endmodule : fpm_ctrl

/* src/fpm_timer.sv */
// fpm_timer: prescaled 10-bit program/erase timer
// assumes start_in is a single-cycle pulse from the control block
module fpm_timer
(
  // clock and reset
  input wire logic core_clk_in,
  input wire logic srst_in,
  // control
  input wire logic start_in,
  input wire logic [7:0] limit_in,
  // result
  output logic done_out,
  output logic [fpm_pkg::FPM_TMR_W-1:0] count_out
);
  import fpm_pkg::*;

  logic [FPM_PRE_W-1:0] pre;
  logic [FPM_PRE_W-1:0] next_pre;
  logic run;
  logic next_run;
  logic next_done;
  logic [FPM_TMR_W-1:0] next_count;
  logic tick;

  always_comb
  begin
    tick = (pre == FPM_PRE_LAST);
    next_pre = start_in ? '0 : pre + 7'h01;
    next_run = run;
    next_count = count_out;
    next_done = 1'b0;
    if (start_in)
    begin
      next_run = 1'b1;
      next_count = '0; // RULE_13
    end
    else if (run && count_out == {2'b00, limit_in})
    begin
      // stops on equality, limit zero ends at once
      next_run = 1'b0; // RULE_13
      next_done = 1'b1;
    end
    else if (run && tick)
    begin
      next_count = count_out + 10'h001;
    end
  end

  always_ff @(posedge core_clk_in)
  begin
    if (srst_in)
    begin
      pre <= '0;
      run <= 1'b0;
      done_out <= 1'b0;
      count_out <= '0;
    end
    else
    begin
      pre <= next_pre;
      run <= next_run;
      done_out <= next_done;
      count_out <= next_count;
    end
  end

  property p_tmr_clear;
    @(posedge core_clk_in) disable iff (srst_in)
    start_in |=> (count_out == 10'h000);
  endproperty
  a_tmr_clear: assert property (p_tmr_clear) // RULE_13
    else $error("timer not cleared at start");

  property p_tmr_stop;
    @(posedge core_clk_in) disable iff (srst_in)
    done_out |-> (count_out == {2'b00, $past(limit_in)});
  endproperty
  a_tmr_stop: assert property (p_tmr_stop) // RULE_13
    else $error("timer stopped away from limit");
endmodule : fpm_timer
